//--- sram_burst2_core.sv
/*
 * SRAM core with its pin synchroniser and read FIFO.
 * Assumes all link pins, clocks too, are slow and asynchronous to sys_clk.
 */
`timescale 1ns/1ps

module pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q2,
   output logic [W-1:0] q3
);
   logic [W-1:0] s1_q;

   // Three stages; only the second stage reads the first.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= '0;
         q2 <= '0;
         q3 <= '0;
      end
      else
      begin
         s1_q <= d;
         q2 <= s1_q;
         q3 <= q2;
      end
   end
endmodule : pin_sync

module burst_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [PW:0] count_q;
   logic push;
   logic pop;

   // Full and empty come from the count.
   assign in_ready = (count_q != (PW+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data = mem_q[rd_ptr_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wr_ptr_q] <= in_data;
   end

   // Pointers wrap since the depth is a power of two.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_q <= wr_ptr_q + 1'b1;
         if (pop)
            rd_ptr_q <= rd_ptr_q + 1'b1;
         if (push && !pop)
            count_q <= count_q + 1'b1;
         else if (pop && !push)
            count_q <= count_q - 1'b1;
      end
   end
endmodule : burst_fifo

// Notes on behaviour
// - Read command and read address are taken at a rising input_timing_rise edge.
// - Every read and write moves exactly two beats at consecutive addresses.
// - Outputs follow the output clocks; return strobes run freely, aligned with data.
// - Single-clock mode: beat one on second input_timing_fall, beat two next rise.
// - An idle_cycle never cuts short a read burst already under way.
// - Write begins at input_timing_rise; its address is taken at the following fall.
// - First write beat rides with the command; the second is taken at the fall.
// - Write bursts wait in buffers and reach the array on the second later write.
// - Reads see buffered and just-arriving write data, keeping full coherency.
// - Each low byte_write_n line enables its lane for that beat only.
// - With write_select_n high at input_timing_rise the array stays untouched.
// - Impedance starts mid-range, settles within 1024 cycles, keeps readjusting.
// - Both output clocks held high selects timing from the input clock pair.
// - Read and write ports run independently and finish pending bursts.
// - Bypass mode launches read data one cycle after the command.
// - DLL resets on bypass low-to-high or both input clocks stopped 30ns.
// - After a DLL reset, lock comes after 2048 stable input clock cycles.
// - Device is ready after lock_wait_cycles; bypass skips locking only.
// - Burst counter is full-width linear; second beat goes to base plus one.
module sram_burst2_core (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic input_timing_rise,
   input wire logic input_timing_fall,
   input wire logic output_timing_true,
   input wire logic output_timing_inv,
   input wire logic read_select_n,
   input wire logic write_select_n,
   input wire logic [sram_burst2_pkg::ADDR_W-1:0] address,
   input wire logic [sram_burst2_pkg::DATA_W-1:0] data_in,
   input wire logic [sram_burst2_pkg::LANES-1:0] byte_write_n,
   input wire logic dll_bypass_n,
   input wire logic [sram_burst2_pkg::IMP_W-1:0] impedance_target,
   output logic [sram_burst2_pkg::DATA_W-1:0] data_out,
   output logic data_oe_n,
   output logic return_strobe_true,
   output logic return_strobe_inv,
   output logic [sram_burst2_pkg::IMP_W-1:0] impedance_code,
   output logic impedance_settled,
   output logic dll_locked,
   output logic device_ready
);
   import sram_burst2_pkg::*;

   pins_t pins_raw;
   pins_t p2;
   pins_t p3;
   logic [3:0] clk2;
   logic [3:0] clk3;
   logic [3:0] clk_lvl_q;
   logic [3:0] clk_rise;
   logic k_rise_e;
   logic k_fall_e;
   logic k_any_e;
   logic single_mode;
   logic launch_rise;
   logic launch_fall;
   rd_slot_t rp0_q;
   rd_slot_t rp1_q;
   rd_slot_t rp2_q;
   logic beat_go;
   logic [ADDR_W-1:0] beat_addr;
   logic [DATA_W-1:0] beat_data;
   logic wr_open_q;
   logic [DATA_W-1:0] wr_d0_q;
   logic [LANES-1:0] wr_bw0_q;
   wr_entry_t new_ent;
   wr_entry_t wb_q [NWB];
   logic [DATA_W-1:0] array_q [2**ADDR_W];
   logic push_q;
   logic [DATA_W-1:0] push_data_q;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [DATA_W-1:0] fifo_out_data;
   logic [OUT_DLY-1:0] rise_dly_q;
   logic [OUT_DLY-1:0] fall_dly_q;
   logic out_edge;
   logic [3:0] stop_cnt_q;
   logic byp_lvl_q;
   logic dll_reset_ev;
   dll_state_t dll_state_q;
   logic [11:0] lock_cnt_q;
   logic [5:0] imp_step_q;
   logic [10:0] imp_settle_q;

   // A low enable replaces that lane of the base word.
   function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] base,
                                                    input logic [DATA_W-1:0] upd,
                                                    input logic [LANES-1:0] en_n);
      logic [DATA_W-1:0] r;
      r = base;
      for (int i = 0; i < LANES; i++)
      begin
         if (!en_n[i])
            r[i*LANE_W +: LANE_W] = upd[i*LANE_W +: LANE_W];
      end
      return r;
   endfunction : lane_merge

   // All pins share one three-stage synchroniser.
   assign pins_raw = '{k_rise: input_timing_rise, k_fall: input_timing_fall, c_true: output_timing_true,
                       c_inv: output_timing_inv, rd_n: read_select_n, wr_n: write_select_n, addr: address,
                       din: data_in, bw_n: byte_write_n, bypass_n: dll_bypass_n, imp_tgt: impedance_target};

   pin_sync #(
      .W($bits(pins_t))
   ) u_sync (
      .clk(sys_clk),
      .rst_n(rst_n),
      .d(pins_raw),
      .q2(p2),
      .q3(p3)
   );

   // A clock level counts only once stages two and three agree.
   assign clk2 = {p2.c_inv, p2.c_true, p2.k_fall, p2.k_rise};
   assign clk3 = {p3.c_inv, p3.c_true, p3.k_fall, p3.k_rise};
   assign clk_rise = (clk2 & clk3) & ~clk_lvl_q;
   assign k_rise_e = clk_rise[0];
   assign k_fall_e = clk_rise[1];
   assign k_any_e = ((clk2[1:0] == clk3[1:0]) && (clk3[1:0] != clk_lvl_q[1:0]));

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         clk_lvl_q <= '0;
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (clk2[i] == clk3[i])
               clk_lvl_q[i] <= clk3[i];
         end
      end
   end

   // Both output clocks high: tied off, so the input pair times the outputs.
   assign single_mode = clk_lvl_q[2] & clk_lvl_q[3];
   assign launch_rise = single_mode ? k_rise_e : clk_rise[2];
   assign launch_fall = single_mode ? k_fall_e : clk_rise[3];

   // Read pipe: command, one cycle of wait, then the burst owing its second beat.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rp0_q <= '0;
         rp1_q <= '0;
         rp2_q <= '0;
      end
      else
      begin
         if (!p3.bypass_n)
         begin
            if (launch_rise)
            begin
               rp2_q <= rp0_q;
               rp0_q.valid <= 1'b0;
            end
            if (launch_fall)
               rp2_q.valid <= 1'b0;
         end
         else
         begin
            if (launch_fall)
            begin
               rp1_q <= rp0_q;
               rp0_q.valid <= 1'b0;
               rp2_q <= rp1_q;
            end
            else if (launch_rise)
               rp2_q.valid <= 1'b0;
         end
         // An idle_cycle loads an empty slot; later bursts stay untouched.
         if (k_rise_e)
            rp0_q <= '{valid: !p3.rd_n, addr: p3.addr};
      end
   end

   // Pick the beat due at this launch edge.
   always_comb
   begin
      beat_go = 1'b0;
      beat_addr = '0;
      if (!p3.bypass_n)
      begin
         if (launch_rise && rp0_q.valid)
         begin
            beat_go = 1'b1;
            beat_addr = rp0_q.addr;
         end
         else if (launch_fall && rp2_q.valid)
         begin
            beat_go = 1'b1;
            beat_addr = ADDR_W'(rp2_q.addr + 1'b1);
         end
      end
      else
      begin
         if (launch_fall && rp1_q.valid)
         begin
            beat_go = 1'b1;
            beat_addr = rp1_q.addr;
         end
         else if (launch_rise && rp2_q.valid)
         begin
            beat_go = 1'b1;
            beat_addr = ADDR_W'(rp2_q.addr + 1'b1);
         end
      end
   end

   // A write burst closes at the fall edge with its address and second beat.
   assign new_ent = '{valid: wr_open_q & k_fall_e, addr: p3.addr, data0: wr_d0_q, data1: p3.din,
                      bw0_n: wr_bw0_q, bw1_n: p3.bw_n};

   // Array word overlaid by buffered writes, oldest first, then the burst closing now.
   always_comb
   begin
      beat_data = array_q[beat_addr];
      for (int e = NWB - 1; e >= 0; e--)
      begin
         if (wb_q[e].valid && wb_q[e].addr == beat_addr)
            beat_data = lane_merge(beat_data, wb_q[e].data0, wb_q[e].bw0_n);
         if (wb_q[e].valid && ADDR_W'(wb_q[e].addr + 1'b1) == beat_addr)
            beat_data = lane_merge(beat_data, wb_q[e].data1, wb_q[e].bw1_n);
      end
      if (new_ent.valid && new_ent.addr == beat_addr)
         beat_data = lane_merge(beat_data, new_ent.data0, new_ent.bw0_n);
      if (new_ent.valid && ADDR_W'(new_ent.addr + 1'b1) == beat_addr)
         beat_data = lane_merge(beat_data, new_ent.data1, new_ent.bw1_n);
   end

   // Write capture and buffer shift; a high write_select_n opens nothing.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_open_q <= 1'b0;
         wr_d0_q <= '0;
         wr_bw0_q <= '1;
         for (int e = 0; e < NWB; e++)
            wb_q[e] <= '0;
      end
      else
      begin
         if (k_rise_e)
         begin
            wr_open_q <= !p3.wr_n;
            wr_d0_q <= p3.din;
            wr_bw0_q <= p3.bw_n;
         end
         else if (k_fall_e)
            wr_open_q <= 1'b0;
         if (new_ent.valid)
         begin
            wb_q[0] <= new_ent;
            for (int e = 1; e < NWB; e++)
               wb_q[e] <= wb_q[e-1];
         end
      end
   end

   // The oldest buffered burst reaches the array only when a later write pushes it out.
   always_ff @(posedge sys_clk)
   begin
      if (new_ent.valid && wb_q[NWB-1].valid)
      begin
         array_q[wb_q[NWB-1].addr] <= lane_merge(array_q[wb_q[NWB-1].addr], wb_q[NWB-1].data0,
                                                 wb_q[NWB-1].bw0_n);
         array_q[ADDR_W'(wb_q[NWB-1].addr + 1'b1)] <= lane_merge(array_q[ADDR_W'(wb_q[NWB-1].addr + 1'b1)],
                                                                 wb_q[NWB-1].data1, wb_q[NWB-1].bw1_n);
      end
   end

   // One-word hold before the FIFO; a new beat overwrites a waiting one.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         push_q <= 1'b0;
         push_data_q <= '0;
      end
      else
      begin
         push_q <= beat_go | (push_q & !fifo_in_ready);
         if (beat_go)
            push_data_q <= beat_data;
      end
   end

   // Beats drain on delayed launch edges, once the device is ready.
   assign out_edge = rise_dly_q[OUT_DLY-1] | fall_dly_q[OUT_DLY-1];
   assign fifo_out_ready = out_edge & (dll_state_q == DLL_READY);

   burst_fifo #(
      .W(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(sys_clk),
      .rst_n(rst_n),
      .in_valid(push_q),
      .in_ready(fifo_in_ready),
      .in_data(push_data_q),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // Strobes and data share one delayed edge so their timing matches.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rise_dly_q <= '0;
         fall_dly_q <= '0;
         return_strobe_true <= 1'b0;
         return_strobe_inv <= 1'b1;
         data_out <= '0;
         data_oe_n <= 1'b1;
      end
      else
      begin
         rise_dly_q <= {rise_dly_q[OUT_DLY-2:0], launch_rise};
         fall_dly_q <= {fall_dly_q[OUT_DLY-2:0], launch_fall};
         if (rise_dly_q[OUT_DLY-1])
         begin
            return_strobe_true <= 1'b1;
            return_strobe_inv <= 1'b0;
         end
         else if (fall_dly_q[OUT_DLY-1])
         begin
            return_strobe_true <= 1'b0;
            return_strobe_inv <= 1'b1;
         end
         if (out_edge)
         begin
            data_oe_n <= !(fifo_out_valid & fifo_out_ready);
            if (fifo_out_ready && fifo_out_valid)
               data_out <= fifo_out_data;
         end
      end
   end

   // Stopped-clock and bypass-release detection for the DLL.
   assign dll_reset_ev = (stop_cnt_q == STOP_CYC) | (p3.bypass_n & !byp_lvl_q);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stop_cnt_q <= '0;
         byp_lvl_q <= 1'b0;
      end
      else
      begin
         byp_lvl_q <= p3.bypass_n;
         if (k_any_e)
            stop_cnt_q <= '0;
         else if (stop_cnt_q != STOP_CYC)
            stop_cnt_q <= stop_cnt_q + 1'b1;
      end
   end

   // DLL sequencing; bypass still waits the full count because internal logic initialises then.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dll_state_q <= DLL_RESET;
         lock_cnt_q <= '0;
         dll_locked <= 1'b0;
         device_ready <= 1'b0;
      end
      else
      begin
         case (dll_state_q)
            DLL_RESET:
            begin
               lock_cnt_q <= '0;
               if (!dll_reset_ev && k_rise_e)
                  dll_state_q <= DLL_WAIT;
            end
            DLL_WAIT:
            begin
               if (dll_reset_ev)
                  dll_state_q <= DLL_RESET;
               else if (k_rise_e)
               begin
                  lock_cnt_q <= lock_cnt_q + 1'b1;
                  if (lock_cnt_q == LOCK_WAIT_CYC - 1'b1)
                     dll_state_q <= DLL_READY;
               end
            end
            DLL_READY:
            begin
               if (dll_reset_ev)
                  dll_state_q <= DLL_RESET;
            end
            default:
               dll_state_q <= DLL_RESET;
         endcase
         device_ready <= (dll_state_q == DLL_READY);
         dll_locked <= (dll_state_q == DLL_READY) & p3.bypass_n;
      end
   end

   // Impedance steps toward the target once per interval while clocks run.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         impedance_code <= IMP_MID;
         imp_step_q <= '0;
         imp_settle_q <= '0;
         impedance_settled <= 1'b0;
      end
      else if (k_rise_e)
      begin
         imp_step_q <= (imp_step_q == IMP_STEP_CYC - 1'b1) ? '0 : imp_step_q + 1'b1;
         if (imp_step_q == IMP_STEP_CYC - 1'b1)
         begin
            if (impedance_code < p3.imp_tgt)
               impedance_code <= impedance_code + 1'b1;
            else if (impedance_code > p3.imp_tgt)
               impedance_code <= impedance_code - 1'b1;
         end
         if (imp_settle_q != IMP_SETTLE_CYC)
            imp_settle_q <= imp_settle_q + 1'b1;
         else
            impedance_settled <= 1'b1;
      end
   end

endmodule : sram_burst2_core

//--- sram_burst2_pkg.sv
/*
 * Constants and types of the burst-of-two SRAM core.
 * Assumes a 250 MHz clock samples every link pin.
 */
package sram_burst2_pkg;

   // Array and bus shape.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 36;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int NWB = 2;
   localparam int FIFO_DEPTH = 16;

   // System clock and stopped-clock detection.
   localparam int SYS_PERIOD_NS = 4;
   localparam int STOP_TIME_NS = 30;
   localparam logic [3:0] STOP_CYC = 4'((STOP_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);

   // Input clock cycles for DLL lock and for impedance settling.
   localparam logic [11:0] LOCK_WAIT_CYC = 12'h800;
   localparam int IMP_W = 6;
   localparam logic [IMP_W-1:0] IMP_MID = 6'h20;
   localparam logic [10:0] IMP_SETTLE_CYC = 11'h400;
   localparam logic [5:0] IMP_STEP_CYC = 6'(IMP_SETTLE_CYC / (2 ** (IMP_W - 1)));

   // Delay-line stages from launch edge to the output register, strobes alike.
   localparam int OUT_DLY = 3;

   // All pins of the link, sampled together.
   typedef struct packed {
      logic k_rise;
      logic k_fall;
      logic c_true;
      logic c_inv;
      logic rd_n;
      logic wr_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] din;
      logic [LANES-1:0] bw_n;
      logic bypass_n;
      logic [IMP_W-1:0] imp_tgt;
   } pins_t;

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
   } rd_slot_t;

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data0;
      logic [DATA_W-1:0] data1;
      logic [LANES-1:0] bw0_n;
      logic [LANES-1:0] bw1_n;
   } wr_entry_t;

   typedef enum logic [2:0] {
      DLL_RESET = 3'h1,
      DLL_WAIT = 3'h2,
      DLL_READY = 3'h4
   } dll_state_t;

endpackage : sram_burst2_pkg

//--- sram_burst2_properties.sv
/*
 * Checker of the SRAM core: strobes, bus, impedance, DLL.
 * Assumes it sees only the core's ports.
 */
`timescale 1ns/1ps

module sram_burst2_properties (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic input_timing_rise,
   input wire logic dll_bypass_n,
   input wire logic data_oe_n,
   input wire logic return_strobe_true,
   input wire logic return_strobe_inv,
   input wire logic [sram_burst2_pkg::IMP_W-1:0] impedance_code,
   input wire logic impedance_settled,
   input wire logic dll_locked,
   input wire logic device_ready
);
   import sram_burst2_pkg::*;

   logic k_q;
   logic [12:0] rises_q;

   // Counts raw input clock rises while not ready.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         k_q <= 1'b0;
         rises_q <= 13'h0;
      end
      else
      begin
         k_q <= input_timing_rise;
         rises_q <= device_ready ? 13'h0 : rises_q + 13'(input_timing_rise & ~k_q);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_hold;
      $stable(return_strobe_true) [*4];
   endsequence
   sequence s_drop;
      ##[1:8] !device_ready;
   endsequence

   property p_pair; return_strobe_inv != return_strobe_true; endproperty
   property p_launch; $fell(data_oe_n) |-> $changed(return_strobe_true); endproperty
   property p_half; $changed(return_strobe_true) |=> s_hold; endproperty
   property p_step;
      $changed(impedance_code) |-> impedance_code == $past(impedance_code) + 6'h1
         || impedance_code == $past(impedance_code) - 6'h1;
   endproperty
   property p_settled; impedance_settled |=> impedance_settled; endproperty
   property p_unlock; $fell(dll_bypass_n) |-> ##[1:6] !dll_locked; endproperty
   property p_reset; $rose(dll_bypass_n) |-> s_drop; endproperty
   property p_wait; $rose(device_ready) |-> rises_q >= 13'h800; endproperty

   a_pair: assert property (p_pair)
      else $error("strobes not complementary");
   a_launch: assert property (p_launch)
      else $error("bus driven without strobe edge");
   a_half: assert property (p_half)
      else $error("strobe half period too short");
   a_step: assert property (p_step)
      else $error("impedance jumped more than one step");
   a_settled: assert property (p_settled)
      else $error("impedance settled flag dropped");
   a_unlock: assert property (p_unlock)
      else $error("lock kept in bypass");
   a_reset: assert property (p_reset)
      else $error("bypass release did not reset");
   a_wait: assert property (p_wait)
      else $error("ready before lock wait");
endmodule : sram_burst2_properties

bind sram_burst2_core sram_burst2_properties chk (.sys_clk(sys_clk), .rst_n(rst_n),
   .input_timing_rise(input_timing_rise), .dll_bypass_n(dll_bypass_n), .data_oe_n(data_oe_n),
   .return_strobe_true(return_strobe_true), .return_strobe_inv(return_strobe_inv),
   .impedance_code(impedance_code), .impedance_settled(impedance_settled), .dll_locked(dll_locked),
   .device_ready(device_ready));

//--- ctrl_model.sv
/*
 * Controller model: input clocks, commands, addresses, write data.
 * Assumes requests come via send; halt stops the clocks.
 */
`timescale 1ns/1ps

module ctrl_model (
   input wire logic sys_clk,
   input wire logic halt,
   output logic k_rise,
   output logic k_fall,
   output logic rd_n,
   output logic wr_n,
   output logic [sram_burst2_pkg::ADDR_W-1:0] addr,
   output logic [sram_burst2_pkg::DATA_W-1:0] din,
   output logic [sram_burst2_pkg::LANES-1:0] bw_n
);
   import sram_burst2_pkg::*;

   typedef struct packed {
      logic r_n, w_n;
      logic [ADDR_W-1:0] ra, wa;
      logic [DATA_W-1:0] d0, d1;
      logic [LANES-1:0] b0, b1;
   } req_t;

   req_t pend[$];
   time rd_t;

   task automatic send(input req_t r);
      pend.push_back(r);
   endtask : send

   // Pins move three clocks away from each clock edge.
   task automatic one(input req_t r);
      @(posedge sys_clk);
      rd_n <= r.r_n;
      wr_n <= r.w_n;
      addr <= r.ra;
      din <= r.d0;
      bw_n <= r.b0;
      repeat (3) @(posedge sys_clk);
      k_rise <= 1'b1;
      k_fall <= 1'b0;
      if (!r.r_n)
         rd_t = $time;
      repeat (3) @(posedge sys_clk);
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      addr <= r.wa;
      din <= r.d1;
      bw_n <= r.b1;
      repeat (3) @(posedge sys_clk);
      k_rise <= 1'b0;
      k_fall <= 1'b1;
      repeat (2) @(posedge sys_clk);
   endtask : one

   // Idle cycles invert address and data so stale values never look valid.
   initial
   begin
      k_rise = 1'b0;
      k_fall = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr = '0;
      din = '0;
      bw_n = '1;
      forever
         if (halt)
            @(posedge sys_clk);
         else if (pend.size() > 0)
            one(pend.pop_front());
         else
            one('{1'b1, 1'b1, ~addr, ~addr, ~din, ~din, 4'hf, 4'hf});
   end
endmodule : ctrl_model

//--- sram_burst2_core_test.sv
/*
 * Bench of the SRAM core in single-clock mode.
 * Assumes ctrl_model drives the link pins.
 */
`timescale 1ns/1ps

module sram_burst2_core_test;
   import sram_burst2_pkg::*;

   logic sys_clk, rst_n, bypass_n, halt, kr, kf, rdn, wrn, oe_n, st_t, st_i, settled, locked, ready, st_q;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] din, dout;
   logic [LANES-1:0] bwn;
   logic [IMP_W-1:0] code;
   logic [DATA_W-1:0] exp_mem [256];
   logic [DATA_W-1:0] beats [$];
   time beat_t [$];
   int err_count, checks;
   localparam logic [IMP_W-1:0] TGT = 6'h2a;

   ctrl_model m (.sys_clk(sys_clk), .halt(halt), .k_rise(kr), .k_fall(kf), .rd_n(rdn), .wr_n(wrn),
      .addr(addr), .din(din), .bw_n(bwn));
   sram_burst2_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .input_timing_rise(kr), .input_timing_fall(kf),
      .output_timing_true(1'b1), .output_timing_inv(1'b1), .read_select_n(rdn), .write_select_n(wrn),
      .address(addr), .data_in(din), .byte_write_n(bwn), .dll_bypass_n(bypass_n), .impedance_target(TGT),
      .data_out(dout), .data_oe_n(oe_n), .return_strobe_true(st_t), .return_strobe_inv(st_i),
      .impedance_code(code), .impedance_settled(settled), .dll_locked(locked), .device_ready(ready));

   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // A beat is taken at each strobe toggle on a driven bus.
   always @(posedge sys_clk)
   begin
      st_q <= st_t;
      if (oe_n === 1'b0 && st_t !== st_q)
      begin
         beats.push_back(dout);
         beat_t.push_back($time);
      end
   end

   task automatic report_and_stop();
      if (err_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
      checks++;
      if (got !== want)
      begin
         err_count++;
         $display("[FAIL] %0t got %h want %h", $time, got, want);
      end
   endtask : chk

   // Queues one cycle and updates the expected array per lane.
   task automatic op(input logic r_n, w_n, input logic [ADDR_W-1:0] ra, wa,
                     input logic [DATA_W-1:0] d0, d1, input logic [LANES-1:0] b0, b1);
      for (int l = 0; l < LANES; l++)
         if (!w_n)
         begin
            if (!b0[l]) exp_mem[wa][l*LANE_W +: LANE_W] = d0[l*LANE_W +: LANE_W];
            if (!b1[l]) exp_mem[wa + 8'h1][l*LANE_W +: LANE_W] = d1[l*LANE_W +: LANE_W];
         end
      m.send({r_n, w_n, ra, wa, d0, d1, b0, b1});
   endtask : op

   // Missing beats become unknowns, so the compare fails.
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input int lo, input int hi);
      int n;
      time dt;
      for (n = 0; n < 400 && beats.size() < 2; n++)
         @(posedge sys_clk);
      while (beats.size() < 2)
      begin
         beats.push_back('x);
         beat_t.push_back(0);
      end
      dt = (beat_t[0] - m.rd_t) / 4;
      chk(beats.pop_front(), exp_mem[a]);
      chk(beats.pop_front(), exp_mem[a + 8'h1]);
      void'(beat_t.pop_front());
      void'(beat_t.pop_front());
      if (hi > 0)
         chk(dt >= lo && dt <= hi, 1'b1);
   endtask : rd_chk

   task automatic wait_ready();
      for (int n = 0; n < 30000 && ready !== 1'b1; n++)
         @(posedge sys_clk);
      chk(ready, 1'b1);
   endtask : wait_ready

   task automatic t_ready();
      wait_ready();
      chk(locked, 1'b1);
      chk(settled, 1'b1);
      chk(code, TGT);
      chk(st_i ^ st_t, 1'b1);
      chk(oe_n, 1'b1);
   endtask : t_ready

   task automatic t_coherent();
      op(1, 0, 8'h00, 8'h10, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
      op(0, 1, 8'h10, 8'h10, 36'h0badbad00, 36'h0badbad11, 4'h0, 4'h0);
      rd_chk(8'h10, 24, 30);
      op(0, 0, 8'h10, 8'h10, 36'haaaaaaaaa, 36'h555555555, 4'ha, 4'hf);
      rd_chk(8'h10, 24, 30);
   endtask : t_coherent

   task automatic t_commit();
      op(1, 0, 8'h00, 8'hff, 36'h111111111, 36'h222222222, 4'h0, 4'h0);
      op(1, 0, 8'h00, 8'h30, 36'h333333333, 36'h444444444, 4'h0, 4'h0);
      op(1, 0, 8'h00, 8'h40, 36'h666666666, 36'h777777777, 4'h0, 4'h0);
      op(0, 1, 8'h10, 8'h00, 36'h0, 36'h0, 4'hf, 4'hf);
      op(1, 1, 8'h00, 8'h00, 36'h0, 36'h0, 4'hf, 4'hf);
      op(0, 1, 8'hff, 8'h00, 36'h0, 36'h0, 4'hf, 4'hf);
      rd_chk(8'h10, 0, 0);
      rd_chk(8'hff, 24, 30);
   endtask : t_commit

   task automatic t_bypass();
      @(posedge sys_clk);
      bypass_n <= 1'b0;
      repeat (20) @(posedge sys_clk);
      chk(locked, 1'b0);
      chk(ready, 1'b1);
      op(0, 0, 8'h50, 8'h50, 36'h0f0f0f0f0, 36'h987654321, 4'h0, 4'h0);
      rd_chk(8'h50, 18, 23);
      bypass_n <= 1'b1;
      repeat (10) @(posedge sys_clk);
      chk(ready, 1'b0);
      wait_ready();
   endtask : t_bypass

   task automatic t_stop();
      halt <= 1'b1;
      repeat (36) @(posedge sys_clk);
      chk(ready, 1'b0);
      halt <= 1'b0;
      wait_ready();
      op(0, 1, 8'hff, 8'h00, 36'h0, 36'h0, 4'hf, 4'hf);
      rd_chk(8'hff, 24, 30);
   endtask : t_stop

   initial
   begin
      err_count = 0;
      checks = 0;
      rst_n = 1'b0;
      bypass_n = 1'b0;
      halt = 1'b0;
      repeat (12) @(posedge sys_clk);
      chk(oe_n, 1'b1);
      chk(code, IMP_MID);
      rst_n <= 1'b1;
      bypass_n <= 1'b1;
      t_ready();
      t_coherent();
      t_commit();
      t_bypass();
      t_stop();
      report_and_stop();
   end

   // Four lock waits bound the run.
   initial
   begin
      #400000;
      err_count++;
      report_and_stop();
   end
endmodule : sram_burst2_core_test
